// >>> core/lcr_defs.vh
`ifndef LCR_DEFS_VH
`define LCR_DEFS_VH

// Decode window
`define LCR_BASE_ADDR     17'h1ffe0
`define LCR_ADDR_W        17
`define LCR_NUM_REGS      17
`define LCR_IDX_W         5
`define LCR_LAST_IDX      17'h00010

// Register indices
`define LCR_IDX_REV       5'h00
`define LCR_IDX_MODE0     5'h01
`define LCR_IDX_MODE1     5'h02
`define LCR_IDX_MODE2     5'h03
`define LCR_IDX_HSIZE     5'h04
`define LCR_IDX_VSIZE_LO  5'h05
`define LCR_IDX_VSIZE_HI  5'h06
`define LCR_IDX_LPOS      5'h07
`define LCR_IDX_HBLANK    5'h08
`define LCR_IDX_FPOS      5'h09
`define LCR_IDX_VBLANK    5'h0a
`define LCR_IDX_MODRATE   5'h0b
`define LCR_IDX_S1_LO     5'h0c
`define LCR_IDX_S1_HI     5'h0d
`define LCR_IDX_S2_LO     5'h0e
`define LCR_IDX_S2_HI     5'h0f
`define LCR_IDX_OVF       5'h10

// Writable bit masks
`define LCR_MASK_FULL     8'hff
`define LCR_MASK_VSIZE_HI 8'h03
`define LCR_MASK_6BIT     8'h3f
`define LCR_MASK_FPOS     8'h0f
`define LCR_MASK_OVF      8'h12
`define LCR_MASK_NONE     8'h00

// Reset and idle values
`define LCR_RST_VAL       8'h00
`define LCR_ZERO_BYTE     8'h00
`define LCR_RST_WIDTH     12'h008
`define LCR_RST_HEIGHT    11'h001
`define LCR_RST_START     17'h00000

// Mode 0 field positions
`define LCR_M0_TFT        7
`define LCR_M0_DUAL       6
`define LCR_M0_COLOR      5
`define LCR_M0_LPOL       4
`define LCR_M0_FPOL       3
`define LCR_M0_SMASK      2
`define LCR_M0_DW_HI      1
`define LCR_M0_DW_LO      0

// Mode 1 field positions
`define LCR_M1_BPP_HI     7
`define LCR_M1_BPP_LO     6
`define LCR_M1_HIPERF     5
`define LCR_M1_CLKDIV     4

// Mode 2 field positions
`define LCR_M2_PWR_OVR    3
`define LCR_M2_HWPS_EN    2

// Other field positions
`define LCR_VB_STATUS     7
`define LCR_OVF_S1        1
`define LCR_OVF_S2        4

// Data width codes
`define LCR_DW_4BIT       2'h0
`define LCR_DW_8BIT       2'h1
`define LCR_DW_8BIT_F2    2'h3

// Panel format codes
`define LCR_FMT_MONO_S4   4'h0
`define LCR_FMT_MONO_S8   4'h1
`define LCR_FMT_MONO_D8   4'h2
`define LCR_FMT_COL_S4    4'h3
`define LCR_FMT_COL_S8F1  4'h4
`define LCR_FMT_COL_S8F2  4'h5
`define LCR_FMT_COL_D8    4'h6
`define LCR_FMT_TFT9      4'h7
`define LCR_FMT_TFT12     4'h8
`define LCR_FMT_RESERVED  4'hf

`endif

// >>> core/lcr_regs.v
// How it works
// - Each register answers at the base address plus its index, register one right after register zero.
// - Register zero is read only, giving a product field in its upper six bits and revision in its lower two.
// - Mode register 0 holds the TFT, dual drive and color selects in bits 7, 6 and 5.
// - Panel type bits plus the data width field pick one of nine panel formats, all else reserved.
// - Mode register 0 also holds line and frame pulse polarity and the shift clock mask.
// - Mode register 1 holds the pixel depth, the high performance select and the input clock halving bit.
// - Panel width in pixels is eight times one more than the width register.
// - Panel height in lines is the ten bit size value joined from two registers plus one.
// - Screen 1 start word address joins its low byte, high byte and overflow bit 1 on top.
// - Screen 2 start word address joins its low byte, high byte and overflow bit 4 on top.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
`include "lcr_defs.vh"

module lcr_regs #(
  parameter [5:0] PRODUCT_CODE = 6'h2a,  // Arbitrary value
  parameter [1:0] REVISION     = 2'h0    // Arbitrary value
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rstn,
  // Register port
  input  wire [16:0] addr,
  input  wire [7:0]  wr_data,
  input  wire        wr_en,
  input  wire        rd_en,
  output wire [7:0]  rd_data,
  // Status from the timing logic
  input  wire        vblank_status,
  // Panel type and format
  output wire        panel_is_tft,
  output wire        panel_is_dual,
  output wire        panel_is_color,
  output wire [1:0]  data_width,
  output wire [3:0]  panel_format,
  output wire        panel_format_valid,
  // Pulse control
  output wire        line_pulse_pol,
  output wire        frame_pulse_pol,
  output wire        shift_clock_mask,
  // Pixel depth and clock
  output wire [1:0]  bits_per_pixel,
  output wire        high_perf,
  output wire        input_clk_div2,
  // Power control
  output wire        panel_power_override,
  output wire        hw_power_save_en,
  // Geometry
  output wire [11:0] panel_width_px,
  output wire [10:0] panel_height_lines,
  // Timing fields
  output wire [5:0]  line_pulse_start,
  output wire [5:0]  hblank_period,
  output wire [3:0]  frame_pulse_start,
  output wire [5:0]  vblank_period,
  output wire [5:0]  ac_modulation_rate,
  // Screen start addresses
  output wire [16:0] screen1_start,
  output wire [16:0] screen2_start
);

  // Address decode
  wire [16:0]          addr_off;
  wire                 addr_hit;
  wire [`LCR_IDX_W-1:0] reg_idx;
  wire                 wr_hit;

  // Register contents, one byte per index
  wire [8*`LCR_NUM_REGS-1:0] reg_flat;

  // Read data
  reg  [7:0]           rd_data_r;
  reg  [7:0]           rd_data_nxt;

  // Panel format decode results
  reg  [3:0]           fmt_r;
  reg  [3:0]           fmt_nxt;
  reg                  fmt_valid_r;
  reg                  fmt_valid_nxt;

  // Geometry results
  reg  [11:0]          width_r;
  reg  [11:0]          width_nxt;
  reg  [10:0]          height_r;
  reg  [10:0]          height_nxt;

  // Assembled start addresses
  reg  [16:0]          s1_r;
  reg  [16:0]          s1_nxt;
  reg  [16:0]          s2_r;
  reg  [16:0]          s2_nxt;

  // Named views of stored bytes
  wire [7:0]           mode0;
  wire [7:0]           mode1;
  wire [7:0]           mode2;
  wire [7:0]           hsize;
  wire [7:0]           vsize_lo;
  wire [7:0]           vsize_hi;
  wire [7:0]           ovf;

  // Writable mask per index
  function [7:0] wr_mask;
    input integer idx;
    begin
      case (idx)
        `LCR_IDX_REV:      wr_mask = `LCR_MASK_NONE;
        `LCR_IDX_VSIZE_HI: wr_mask = `LCR_MASK_VSIZE_HI;
        `LCR_IDX_LPOS:     wr_mask = `LCR_MASK_6BIT;
        `LCR_IDX_HBLANK:   wr_mask = `LCR_MASK_6BIT;
        `LCR_IDX_FPOS:     wr_mask = `LCR_MASK_FPOS;
        `LCR_IDX_VBLANK:   wr_mask = `LCR_MASK_6BIT;
        `LCR_IDX_MODRATE:  wr_mask = `LCR_MASK_6BIT;
        `LCR_IDX_OVF:      wr_mask = `LCR_MASK_OVF;
        default:           wr_mask = `LCR_MASK_FULL;
      endcase
    end
  endfunction

  // Base plus index decode
  assign addr_off = addr - `LCR_BASE_ADDR;
  assign addr_hit = (addr >= `LCR_BASE_ADDR) && (addr_off <= `LCR_LAST_IDX);
  assign reg_idx  = addr_off[`LCR_IDX_W-1:0];
  assign wr_hit   = wr_en && addr_hit;

  // Storage, one byte per index
  genvar gi;
  generate
    for (gi = 0; gi < `LCR_NUM_REGS; gi = gi + 1)
    begin : g_reg
      if (gi == `LCR_IDX_REV)
      begin : g_rev
        // Fixed identity, writes dropped
        assign reg_flat[8*gi +: 8] = {PRODUCT_CODE, REVISION};
      end
      else
      begin : g_rw
        reg [7:0] val_r;
        // Masked write, reserved bits stay zero
        always @(posedge ref_clk or negedge rstn)
        begin
          if (!rstn)
            val_r <= `LCR_RST_VAL;
          else if (wr_hit && (reg_idx == gi))
            val_r <= wr_data & wr_mask(gi);
        end
        if (gi == `LCR_IDX_VBLANK)
        begin : g_vb
          // Live blank state in the top bit
          assign reg_flat[8*gi +: 8] = {vblank_status, val_r[6:0]};
        end
        else
        begin : g_pl
          assign reg_flat[8*gi +: 8] = val_r;
        end
      end
    end
  endgenerate

  // Named views
  assign mode0    = reg_flat[8*`LCR_IDX_MODE0 +: 8];
  assign mode1    = reg_flat[8*`LCR_IDX_MODE1 +: 8];
  assign mode2    = reg_flat[8*`LCR_IDX_MODE2 +: 8];
  assign hsize    = reg_flat[8*`LCR_IDX_HSIZE +: 8];
  assign vsize_lo = reg_flat[8*`LCR_IDX_VSIZE_LO +: 8];
  assign vsize_hi = reg_flat[8*`LCR_IDX_VSIZE_HI +: 8];
  assign ovf      = reg_flat[8*`LCR_IDX_OVF +: 8];

  // Read mux, unmapped reads give zero
  always @*
  begin
    rd_data_nxt = `LCR_ZERO_BYTE;
    if (rd_en && addr_hit)
      rd_data_nxt = reg_flat[8*reg_idx +: 8];
  end

  // Panel format decode
  always @*
  begin
    fmt_nxt       = `LCR_FMT_RESERVED;
    fmt_valid_nxt = 1'b0;
    if (mode0[`LCR_M0_TFT])
    begin
      // Dual select ignored for TFT
      case (mode0[1:0])
        `LCR_DW_4BIT:
        begin
          fmt_nxt       = `LCR_FMT_TFT9;
          fmt_valid_nxt = 1'b1;
        end
        `LCR_DW_8BIT:
        begin
          fmt_nxt       = `LCR_FMT_TFT12;
          fmt_valid_nxt = 1'b1;
        end
        default:
        begin
          fmt_nxt       = `LCR_FMT_RESERVED;
          fmt_valid_nxt = 1'b0;
        end
      endcase
    end
    else
    begin
      case ({mode0[`LCR_M0_COLOR], mode0[`LCR_M0_DUAL], mode0[1:0]})
        {2'b00, `LCR_DW_4BIT}:
        begin
          fmt_nxt       = `LCR_FMT_MONO_S4;
          fmt_valid_nxt = 1'b1;
        end
        {2'b00, `LCR_DW_8BIT}:
        begin
          fmt_nxt       = `LCR_FMT_MONO_S8;
          fmt_valid_nxt = 1'b1;
        end
        {2'b01, `LCR_DW_8BIT}:
        begin
          fmt_nxt       = `LCR_FMT_MONO_D8;
          fmt_valid_nxt = 1'b1;
        end
        {2'b10, `LCR_DW_4BIT}:
        begin
          fmt_nxt       = `LCR_FMT_COL_S4;
          fmt_valid_nxt = 1'b1;
        end
        {2'b10, `LCR_DW_8BIT}:
        begin
          fmt_nxt       = `LCR_FMT_COL_S8F1;
          fmt_valid_nxt = 1'b1;
        end
        {2'b10, `LCR_DW_8BIT_F2}:
        begin
          fmt_nxt       = `LCR_FMT_COL_S8F2;
          fmt_valid_nxt = 1'b1;
        end
        {2'b11, `LCR_DW_8BIT}:
        begin
          fmt_nxt       = `LCR_FMT_COL_D8;
          fmt_valid_nxt = 1'b1;
        end
        default:
        begin
          fmt_nxt       = `LCR_FMT_RESERVED;
          fmt_valid_nxt = 1'b0;
        end
      endcase
    end
  end

  // Geometry, extra top bit keeps the carry of a full size value
  always @*
  begin
    width_nxt  = {({1'b0, hsize} + 9'h001), 3'h0};
    height_nxt = {1'b0, vsize_hi[1:0], vsize_lo} + 11'h001;
  end

  // Start addresses, overflow bit on top of each word address
  always @*
  begin
    s1_nxt     = {ovf[`LCR_OVF_S1],
                  reg_flat[8*`LCR_IDX_S1_HI +: 8],
                  reg_flat[8*`LCR_IDX_S1_LO +: 8]};
    s2_nxt     = {ovf[`LCR_OVF_S2],
                  reg_flat[8*`LCR_IDX_S2_HI +: 8],
                  reg_flat[8*`LCR_IDX_S2_LO +: 8]};
  end

  // Read data flop, back to zero once the strobe is gone
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data_r <= `LCR_ZERO_BYTE;
    else
      rd_data_r <= rd_data_nxt;
  end

  // Derived output flops, one cycle behind the stored bytes
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fmt_r       <= `LCR_FMT_MONO_S4;
      fmt_valid_r <= 1'b1;
      width_r     <= `LCR_RST_WIDTH;
      height_r    <= `LCR_RST_HEIGHT;
      s1_r        <= `LCR_RST_START;
      s2_r        <= `LCR_RST_START;
    end
    else
    begin
      fmt_r       <= fmt_nxt;
      fmt_valid_r <= fmt_valid_nxt;
      width_r     <= width_nxt;
      height_r    <= height_nxt;
      s1_r        <= s1_nxt;
      s2_r        <= s2_nxt;
    end
  end

  // Read port
  assign rd_data = rd_data_r;

  // Panel type fields
  assign panel_is_tft       = mode0[`LCR_M0_TFT];
  assign panel_is_dual      = mode0[`LCR_M0_DUAL];
  assign panel_is_color     = mode0[`LCR_M0_COLOR];
  assign data_width         = mode0[`LCR_M0_DW_HI:`LCR_M0_DW_LO];

  // Registered format decode
  assign panel_format       = fmt_r;
  assign panel_format_valid = fmt_valid_r;

  // Pulse control fields
  assign line_pulse_pol   = mode0[`LCR_M0_LPOL];
  assign frame_pulse_pol  = mode0[`LCR_M0_FPOL];
  assign shift_clock_mask = mode0[`LCR_M0_SMASK];

  // Pixel depth and clock fields
  assign bits_per_pixel = mode1[`LCR_M1_BPP_HI:`LCR_M1_BPP_LO];
  assign high_perf      = mode1[`LCR_M1_HIPERF];
  assign input_clk_div2 = mode1[`LCR_M1_CLKDIV];

  // Power fields
  assign panel_power_override = mode2[`LCR_M2_PWR_OVR];
  assign hw_power_save_en     = mode2[`LCR_M2_HWPS_EN];

  // Geometry
  assign panel_width_px     = width_r;
  assign panel_height_lines = height_r;

  // Horizontal timing fields
  assign line_pulse_start   = reg_flat[8*`LCR_IDX_LPOS +: 6];
  assign hblank_period      = reg_flat[8*`LCR_IDX_HBLANK +: 6];

  // Vertical timing fields, status bit kept out of the period
  assign frame_pulse_start  = reg_flat[8*`LCR_IDX_FPOS +: 4];
  assign vblank_period      = reg_flat[8*`LCR_IDX_VBLANK +: 6];

  // Modulation rate, reserved top bits dropped
  assign ac_modulation_rate = reg_flat[8*`LCR_IDX_MODRATE +: 6];

  // Start addresses
  assign screen1_start = s1_r;
  assign screen2_start = s2_r;

endmodule

// >>> test/lcr_regs_props.sv
`timescale 1ns/100ps
`include "lcr_defs.vh"
// Bus and decode checks on the register bank ports
module lcr_regs_props #(
  parameter [5:0] PRODUCT_CODE = 6'h2a,
  parameter [1:0] REVISION     = 2'h0
) (
  // Clock and reset
  input wire        ref_clk,
  input wire        rstn,
  // Register port
  input wire [16:0] addr,
  input wire [7:0]  wr_data,
  input wire        wr_en,
  input wire        rd_en,
  input wire [7:0]  rd_data,
  input wire        vblank_status,
  // Decoded outputs
  input wire        panel_is_tft,
  input wire [1:0]  data_width,
  input wire [3:0]  panel_format,
  input wire        panel_format_valid,
  input wire [11:0] panel_width_px,
  input wire [10:0] panel_height_lines,
  input wire [16:0] screen1_start,
  input wire [16:0] screen2_start
);
  localparam [16:0] B = `LCR_BASE_ADDR;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_rev_read: assert property (rd_en && addr == B |=> rd_data == {PRODUCT_CODE, REVISION})
    else $error("revision read wrong");
  a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data not idle");
  a_unmapped_rd: assert property (rd_en && (addr < B || addr > B + 17'h10) |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_vblank_read: assert property (rd_en && addr == B + 17'h0a |=>
    rd_data[7] == $past(vblank_status) && !rd_data[6])
    else $error("blank status read wrong");
  a_width_calc: assert property (wr_en && addr == B + 17'h04 |->
    ##2 panel_width_px == {1'b0, $past(wr_data, 2), 3'h0} + 12'h008)
    else $error("width wrong");
  a_height_low: assert property (wr_en && addr == B + 17'h05 |->
    ##2 panel_height_lines[7:0] == $past(wr_data, 2) + 8'h01)
    else $error("height wrong");
  a_s1_low: assert property (wr_en && addr == B + 17'h0c |-> ##2 screen1_start[7:0] == $past(wr_data, 2))
    else $error("screen 1 start wrong");
  a_s2_high: assert property (wr_en && addr == B + 17'h0f |-> ##2 screen2_start[15:8] == $past(wr_data, 2))
    else $error("screen 2 start wrong");
  a_tft_format: assert property (panel_is_tft && !data_width[1] |=> panel_format_valid &&
    panel_format == (($past(data_width) == 2'h1) ? 4'h8 : 4'h7))
    else $error("thin film format wrong");

  c_rev_read: cover property (rd_en && addr == B);
  c_tft: cover property (panel_is_tft && data_width == 2'h1);
  c_ovf: cover property (wr_en && addr == B + 17'h10);
endmodule

bind lcr_regs lcr_regs_props #(.PRODUCT_CODE(PRODUCT_CODE), .REVISION(REVISION)) chk_u (.*);

// >>> test/lcr_timing_model.sv
`timescale 1ns/100ps
// Timing logic stand-in: drives the non-display state
module lcr_timing_model (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       rstn,
  // Period and state
  input  wire [5:0] vblank_period,
  output reg        vblank_status
);
  reg [5:0] cnt_r;
  // Flip state after each programmed period
  always @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r         <= 6'h00;
      vblank_status <= 1'b0;
    end
    else if (cnt_r >= vblank_period)
    begin
      cnt_r         <= 6'h00;
      vblank_status <= ~vblank_status;
    end
    else
      cnt_r <= cnt_r + 6'h01;
  end
endmodule

// >>> test/lcr_regs_tb.sv
`timescale 1ns/100ps
`include "lcr_defs.vh"
module lcr_regs_tb;
  localparam [5:0] PCODE = 6'h15; // Arbitrary value
  localparam [1:0] REV   = 2'h2;  // Arbitrary value
  reg         ref_clk, rstn, wr_en, rd_en, vb_q;
  reg  [16:0] addr;
  reg  [7:0]  wr_data, v;
  integer     error_cnt, n_tests, i;
  wire        vblank_status, panel_is_tft, panel_is_dual, panel_is_color, panel_format_valid;
  wire        line_pulse_pol, frame_pulse_pol, shift_clock_mask, high_perf, input_clk_div2;
  wire        panel_power_override, hw_power_save_en;
  wire [1:0]  data_width, bits_per_pixel;
  wire [3:0]  panel_format, frame_pulse_start;
  wire [5:0]  line_pulse_start, hblank_period, vblank_period, ac_modulation_rate;
  wire [7:0]  rd_data;
  wire [10:0] panel_height_lines;
  wire [11:0] panel_width_px;
  wire [16:0] screen1_start, screen2_start;

  lcr_regs #(.PRODUCT_CODE(PCODE), .REVISION(REV)) dut_u (.*);
  lcr_timing_model far_u (.*);

  // 20 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // Blank state as the bank samples it
  always @(posedge ref_clk) vb_q <= vblank_status;

  task finish_test;
  begin
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // One bus cycle, taken at the next edge
  task bus(input w, input r, input [16:0] a, input [7:0] d);
  begin
    addr    <= a;
    wr_en   <= w;
    rd_en   <= r;
    wr_data <= d;
    @(posedge ref_clk);
  end
  endtask

  task wr(input [5:0] idx, input [7:0] d);
    bus(1'b1, 1'b0, `LCR_BASE_ADDR + idx, d);
  endtask

  // Read, judge data in the following cycle, return on an edge
  task rd_at(input [16:0] a, input [7:0] e);
  begin
    bus(1'b0, 1'b1, a, 8'h00);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, (a == `LCR_BASE_ADDR + 17'h0a) ? {vb_q, e[6:0]} : e);
    @(posedge ref_clk);
  end
  endtask

  task rd(input [5:0] idx, input [7:0] e);
    rd_at(`LCR_BASE_ADDR + idx, e);
  endtask

  task idle(input integer n);
    repeat (n) bus(1'b0, 1'b0, addr, 8'h00);
  endtask

  // Expected read back after writing d
  function [7:0] rb(input [5:0] idx, input [7:0] d);
    case (idx)
      6'h00: rb = {PCODE, REV};
      6'h06: rb = d & 8'h03;
      6'h07, 6'h08, 6'h0a, 6'h0b: rb = d & 8'h3f;
      6'h09: rb = d & 8'h0f;
      6'h10: rb = d & 8'h12;
      default: rb = idx < 6'h11 ? d : 8'h00;
    endcase
  endfunction

  // Valid flag and format code from {tft, dual, color, width}
  function [4:0] fmt(input [4:0] s);
    casez (s)
      5'b1??00: fmt = 5'h17;
      5'b1??01: fmt = 5'h18;
      5'b00000: fmt = 5'h10;
      5'b00001: fmt = 5'h11;
      5'b01001: fmt = 5'h12;
      5'b00100: fmt = 5'h13;
      5'b00101: fmt = 5'h14;
      5'b00111: fmt = 5'h15;
      5'b01101: fmt = 5'h16;
      default: fmt = 5'h0f;
    endcase
  endfunction

  task do_reset;
  begin
    rstn <= 1'b0;
    idle(20);
    rstn <= 1'b1;
    @(posedge ref_clk);
  end
  endtask

  task t_reset;
  begin
    #1;
    chk({panel_width_px, panel_height_lines}, {12'h008, 11'h001});
    chk({panel_format_valid, panel_format, screen1_start}, {5'h10, 17'h0});
    chk({screen2_start, bits_per_pixel, high_perf, input_clk_div2, panel_power_override, hw_power_save_en,
         line_pulse_pol, frame_pulse_pol, shift_clock_mask, panel_is_tft, panel_is_dual, panel_is_color,
         data_width}, 32'h0);
    @(posedge ref_clk);
    for (i = 0; i < 17; i = i + 1)
      rd(i[5:0], rb(i[5:0], 8'h00));
    $display("t_reset done");
  end
  endtask

  task t_rw;
  begin
    for (i = 0; i < 18; i = i + 1)
    begin
      wr(i[5:0], 8'hff);
      rd(i[5:0], rb(i[5:0], 8'hff));
      wr(i[5:0], 8'h5a);
      rd(i[5:0], rb(i[5:0], 8'h5a));
    end
    bus(1'b1, 1'b0, 17'h1ffdf, 8'hff);
    rd_at(17'h1ffdf, 8'h00);
    $display("t_rw done");
  end
  endtask

  task t_geom;
  begin
    wr(6'h04, 8'hff);
    wr(6'h05, 8'hff);
    wr(6'h06, 8'hff);
    idle(2);
    chk({panel_width_px, panel_height_lines}, {12'h800, 11'h400});
    wr(6'h04, 8'h13);
    wr(6'h06, 8'hfd);
    wr(6'h05, 8'h2c);
    idle(2);
    chk({panel_width_px, panel_height_lines}, {12'h0a0, 11'h12d});
    $display("t_geom done");
  end
  endtask

  task t_start;
  begin
    wr(6'h0c, 8'h34);
    wr(6'h0d, 8'h12);
    wr(6'h0e, 8'hcd);
    wr(6'h0f, 8'hab);
    wr(6'h10, 8'h02);
    idle(2);
    chk(screen1_start, 17'h11234);
    chk(screen2_start, 17'h0abcd);
    wr(6'h10, 8'h10);
    idle(2);
    chk({screen1_start[16], screen2_start[16]}, 2'h1);
    $display("t_start done");
  end
  endtask

  task t_fmt;
  begin
    // Last pass sets each pulse bit opposite its panel type bit
    for (i = 0; i < 33; i = i + 1)
    begin
      v = (i == 32) ? 8'h1c : {i[4:2], i[4:2], i[1:0]};
      wr(6'h01, v);
      idle(1);
      #1;
      chk({panel_is_tft, panel_is_dual, panel_is_color, line_pulse_pol, frame_pulse_pol,
           shift_clock_mask, data_width}, v);
      chk({panel_format_valid, panel_format}, fmt({v[7:5], v[1:0]}));
      @(posedge ref_clk);
    end
    $display("t_fmt done");
  end
  endtask

  task t_mode;
  begin
    wr(6'h02, 8'h95);
    wr(6'h03, 8'h08);
    wr(6'h07, 8'hc1);
    wr(6'h08, 8'h82);
    wr(6'h09, 8'h43);
    wr(6'h0a, 8'h04);
    wr(6'h0b, 8'h05);
    idle(1);
    #1;
    chk({bits_per_pixel, high_perf, input_clk_div2}, 4'h9);
    chk({panel_power_override, hw_power_save_en}, 2'h2);
    chk({line_pulse_start, hblank_period, frame_pulse_start, vblank_period, ac_modulation_rate},
        {6'h01, 6'h02, 4'h3, 6'h04, 6'h05});
    @(posedge ref_clk);
    // Opposite levels on every mode bit
    wr(6'h02, 8'h6a);
    wr(6'h03, 8'h04);
    idle(1);
    #1;
    chk({bits_per_pixel, high_perf, input_clk_div2}, 4'h6);
    chk({panel_power_override, hw_power_save_en}, 2'h1);
    @(posedge ref_clk);
    $display("t_mode done");
  end
  endtask

  // Main sequence, with a second reset mid-run
  initial
  begin
    error_cnt = 0;
    n_tests   = 0;
    rstn      = 1'b0;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    addr      = 17'h0;
    wr_data   = 8'h00;
    do_reset;
    t_reset;
    t_rw;
    t_geom;
    t_start;
    t_fmt;
    t_mode;
    do_reset;
    t_reset;
    finish_test;
  end

  // Watchdog at several times the expected run
  initial
  begin
    #(3000 * 50);
    error_cnt = error_cnt + 1;
    finish_test;
  end
endmodule
